/* File: design/oscdc_consts.svh */
// constants for oscillator source and divider control
// Function
// - hold ten-bit relaxation oscillator trim value driving capacitor switches
// - trim field loads from flash information row bits during reset
// - system clock divided by two to the power of low-power divide field
// - new low-power divide takes effect at next rising clock edge
// - pll input divided by pre-divide field plus one
// - any pre-divide change makes the pll lose lock
// - two-bit select picks primary, relaxation or secondary oscillator
// - source change is glitch-free and keeps both oscillators on meanwhile
// - relaxation control bit 7 enables relaxation oscillator, reset from strap
// - relaxation control bit 6 selects 400 kHz standby versus 8 MHz
// - external control bit 7 enables, bit 6 picks crystal or oscillator
// - external control bit 5 low power, bit 4 frequency range
// - rtc control holds enable, band, crystal and low-power bits
// - rtc control bit 0 picks system clock or rtc oscillator
// - watchdog clock control accepts only first write after reset
// - watchdog clock control survives warm reset, cleared only by power-on
// - stop-control bit one gates relaxation feed to watchdog in stop
// - watchdog source bit picks half system clock or relaxation oscillator
// - once relaxation picked for watchdog, low source-select bit cannot set
`ifndef OSCDC_CONSTS_SVH
`define OSCDC_CONSTS_SVH
`define OSCDC_ADDR_TRIM      12'h000
`define OSCDC_ADDR_LPDIV     12'h004
`define OSCDC_ADDR_PREDIV    12'h008
`define OSCDC_ADDR_SRCSEL    12'h00C
`define OSCDC_ADDR_RELAX     12'h010
`define OSCDC_ADDR_EXTOSC    12'h014
`define OSCDC_ADDR_RTC       12'h018
`define OSCDC_ADDR_WDOG      12'h01C
`define OSCDC_ADDR_STATUS    12'h020
`define OSCDC_MASK_TRIM      32'h0000_03FF
`define OSCDC_MASK_LPDIV     32'h0000_000F
`define OSCDC_MASK_PREDIV    32'h0000_0007
`define OSCDC_MASK_SRCSEL    32'h0000_0003
`define OSCDC_MASK_RELAX     32'h0000_00C0
`define OSCDC_MASK_EXTOSC    32'h0000_00F0
`define OSCDC_MASK_RTC       32'h0000_001F
`define OSCDC_MASK_WDOG      32'h0000_000A
`define OSCDC_BIT_HI_EN      7
`define OSCDC_BIT_HI_6       6
`define OSCDC_BIT_EXT_LP     5
`define OSCDC_BIT_EXT_RANGE  4
`define OSCDC_BIT_RTC_EN     4
`define OSCDC_BIT_RTC_BAND   3
`define OSCDC_BIT_RTC_CRYSTAL_VS_OSCILLATOR   2
`define OSCDC_BIT_RTC_LP     1
`define OSCDC_BIT_RTC_SRC    0
`define OSCDC_BIT_WD_STOP    1
`define OSCDC_BIT_WD_SRC     3
`define OSCDC_RST_LPDIV      4'h0
`define OSCDC_RST_PREDIV     3'h0
`define OSCDC_RST_RTC        5'h00
`define OSCDC_RST_WDOG       2'h0
`define OSCDC_SW_SETTLE      4'h4
`endif

/* File: design/oscdc_pkg.sv */
// types for oscillator source and divider control
package oscdc_pkg;
   typedef enum logic [1:0] {OSCDC_SRC_PRIMARY, OSCDC_SRC_RELAX, OSCDC_SRC_SECONDARY} oscdc_src_type;
   typedef enum {OSCDC_SW_IDLE, OSCDC_SW_HOLD} oscdc_sw_type;
endpackage : oscdc_pkg

/* File: design/oscdc_top.sv */
// oscillator source, divider and watchdog clock control with apb slave
//
// Implementation choices: the address map and the APB register port.
`include "oscdc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module oscdc_top #(
   parameter int SETTLE_CYCLES = 4
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        por_nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [9:0]  flash_trim,
   input  wire logic [1:0]  strap_src,
   input  wire logic        strap_relax_on,
   input  wire logic        strap_ext_on,
   input  wire logic        strap_crystal,
   input  wire logic        stop_mode,
   output logic [9:0]       trim_value,
   output logic [3:0]       low_power_divide,
   output logic             sys_clk_en,
   output logic [2:0]       pre_divide,
   output logic             pll_lose_lock,
   output logic [1:0]       pll_src_sel,
   output logic             switching,
   output logic             relax_osc_on,
   output logic             relax_osc_standby,
   output logic             osc_power_on,
   output logic             crystal_vs_oscillator,
   output logic             low_power_drive,
   output logic             ext_range_high,
   output logic             rtc_osc_on,
   output logic             rtc_freq_band,
   output logic             rtc_crystal,
   output logic             rtc_low_power,
   output logic             rtc_source_pick,
   output logic             watchdog_feed_in_stop,
   output logic             watchdog_source_pick,
   output logic             watchdog_relax_feed
);
   initial begin
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) $error("SETTLE_CYCLES out of range");
   end

   logic [9:0]  trim_reg;
   logic [3:0]  lpdiv_reg;
   logic [2:0]  prediv_reg;
   logic [1:0]  srcsel_reg;
   logic [1:0]  relax_reg;
   logic [3:0]  ext_reg;
   logic [4:0]  rtc_reg;
   logic [1:0]  wdog_reg;
   logic        wdog_locked_reg;
   logic [1:0]  active_src_reg;
   logic [7:0]  settle_cnt_reg;
   logic [14:0] div_cnt_reg;
   logic        lose_lock_reg;
   oscdc_pkg::oscdc_sw_type sw_state_reg;

   logic wr;
   logic rd;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   logic mapped;
   always_comb begin
      mapped = hit(paddr, `OSCDC_ADDR_TRIM) || hit(paddr, `OSCDC_ADDR_LPDIV) ||
               hit(paddr, `OSCDC_ADDR_PREDIV) || hit(paddr, `OSCDC_ADDR_SRCSEL) ||
               hit(paddr, `OSCDC_ADDR_RELAX) || hit(paddr, `OSCDC_ADDR_EXTOSC) ||
               hit(paddr, `OSCDC_ADDR_RTC) || hit(paddr, `OSCDC_ADDR_WDOG) ||
               hit(paddr, `OSCDC_ADDR_STATUS);
   end
   assign pslverr = psel && penable && !mapped;

   // trim loads from flash row while reset is held
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         trim_reg <= flash_trim;
      end else if (wr && hit(paddr, `OSCDC_ADDR_TRIM)) begin
         trim_reg <= pwdata[9:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lpdiv_reg <= `OSCDC_RST_LPDIV;
      end else if (wr && hit(paddr, `OSCDC_ADDR_LPDIV)) begin
         lpdiv_reg <= pwdata[3:0];
      end
   end

   // pre-divide; any change of value drops pll lock
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         prediv_reg    <= `OSCDC_RST_PREDIV;
         lose_lock_reg <= 1'b0;
      end else begin
         lose_lock_reg <= 1'b0;
         if (wr && hit(paddr, `OSCDC_ADDR_PREDIV)) begin
            prediv_reg    <= pwdata[2:0];
            lose_lock_reg <= (pwdata[2:0] != prediv_reg);
         end
      end
   end
   assign pll_lose_lock = lose_lock_reg || (stop_mode && !osc_power_on);

   // straps are caught by the clocked reset branch
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         srcsel_reg <= strap_src;
      end else if (wr && hit(paddr, `OSCDC_ADDR_SRCSEL)) begin
         srcsel_reg[1] <= pwdata[1];
         srcsel_reg[0] <= pwdata[0] && !(wdog_reg[1] && !srcsel_reg[0]) ? 1'b1 :
                          (pwdata[0] ? srcsel_reg[0] : 1'b0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         relax_reg <= {strap_relax_on, 1'b0};
      end else if (wr && hit(paddr, `OSCDC_ADDR_RELAX)) begin
         relax_reg <= {pwdata[`OSCDC_BIT_HI_EN], pwdata[`OSCDC_BIT_HI_6]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ext_reg <= {strap_ext_on, strap_crystal, 2'b00};
      end else if (wr && hit(paddr, `OSCDC_ADDR_EXTOSC)) begin
         ext_reg <= pwdata[7:4];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rtc_reg <= `OSCDC_RST_RTC;
      end else if (wr && hit(paddr, `OSCDC_ADDR_RTC)) begin
         rtc_reg <= pwdata[4:0];
      end
   end

   // watchdog control: power-on reset only, one write per reset
   always_ff @(posedge ref_clk) begin
      if (!por_nrst) begin
         wdog_reg <= `OSCDC_RST_WDOG;
      end else if (wr && hit(paddr, `OSCDC_ADDR_WDOG) && !wdog_locked_reg) begin
         wdog_reg <= {pwdata[`OSCDC_BIT_WD_SRC], pwdata[`OSCDC_BIT_WD_STOP]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst || !por_nrst) begin
         wdog_locked_reg <= 1'b0;
      end else if (wr && hit(paddr, `OSCDC_ADDR_WDOG)) begin
         wdog_locked_reg <= 1'b1;
      end
   end

   // glitch-free changeover: hold output, settle, then adopt new source
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sw_state_reg   <= oscdc_pkg::OSCDC_SW_IDLE;
         active_src_reg <= strap_src;
         settle_cnt_reg <= 8'h00;
      end else begin
         case (sw_state_reg)
            oscdc_pkg::OSCDC_SW_IDLE: begin
               if (srcsel_reg != active_src_reg) begin
                  sw_state_reg   <= oscdc_pkg::OSCDC_SW_HOLD;
                  settle_cnt_reg <= 8'(SETTLE_CYCLES - 1);
               end
            end
            oscdc_pkg::OSCDC_SW_HOLD: begin
               if (settle_cnt_reg == 8'h00) begin
                  active_src_reg <= srcsel_reg;
                  sw_state_reg   <= oscdc_pkg::OSCDC_SW_IDLE;
               end else begin
                  settle_cnt_reg <= settle_cnt_reg - 8'h01;
               end
            end
            default: sw_state_reg <= oscdc_pkg::OSCDC_SW_IDLE;
         endcase
      end
   end
   assign switching = (sw_state_reg == oscdc_pkg::OSCDC_SW_HOLD);

   // power-of-two divider enable
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         div_cnt_reg <= 15'h0000;
      end else begin
         div_cnt_reg <= div_cnt_reg + 15'h0001;
      end
   end
   always_comb begin
      sys_clk_en = ((div_cnt_reg & ((15'h0001 << lpdiv_reg) - 15'h0001)) == 15'h0000);
   end

   assign trim_value            = trim_reg;
   assign low_power_divide      = lpdiv_reg;
   assign pre_divide            = prediv_reg;
   assign pll_src_sel           = active_src_reg;
   assign relax_osc_on          = relax_reg[1] || switching;
   assign relax_osc_standby     = relax_reg[0];
   assign osc_power_on          = ext_reg[3] || switching;
   assign crystal_vs_oscillator = ext_reg[2];
   assign low_power_drive       = ext_reg[1];
   assign ext_range_high        = ext_reg[0];
   assign rtc_osc_on            = rtc_reg[`OSCDC_BIT_RTC_EN];
   assign rtc_freq_band         = rtc_reg[`OSCDC_BIT_RTC_BAND];
   assign rtc_crystal           = rtc_reg[`OSCDC_BIT_RTC_CRYSTAL_VS_OSCILLATOR];
   assign rtc_low_power         = rtc_reg[`OSCDC_BIT_RTC_LP];
   assign rtc_source_pick       = rtc_reg[`OSCDC_BIT_RTC_SRC];
   assign watchdog_feed_in_stop = wdog_reg[0];
   assign watchdog_source_pick  = wdog_reg[1];
   assign watchdog_relax_feed   = relax_reg[1] && (!stop_mode || wdog_reg[0]);

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            `OSCDC_ADDR_TRIM:   prdata = {22'h00_0000, trim_reg};
            `OSCDC_ADDR_LPDIV:  prdata = {28'h000_0000, lpdiv_reg};
            `OSCDC_ADDR_PREDIV: prdata = {29'h0000_0000, prediv_reg};
            `OSCDC_ADDR_SRCSEL: prdata = {30'h0000_0000, srcsel_reg};
            `OSCDC_ADDR_RELAX:  prdata = {24'h00_0000, relax_reg, 6'h00};
            `OSCDC_ADDR_EXTOSC: prdata = {24'h00_0000, ext_reg, 4'h0};
            `OSCDC_ADDR_RTC:    prdata = {27'h000_0000, rtc_reg};
            `OSCDC_ADDR_WDOG:   prdata = {28'h000_0000, wdog_reg[1], 1'b0, wdog_reg[0], 1'b0};
            `OSCDC_ADDR_STATUS: prdata = {29'h0000_0000, switching, active_src_reg};
            default:            prdata = 32'h0000_0000;
         endcase
      end
   end

   sequence lpd_write_s;
      wr && hit(paddr, `OSCDC_ADDR_LPDIV);
   endsequence
   lpd_next_edge_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      lpd_write_s |=> low_power_divide == $past(pwdata[3:0])) else $error("lpd not applied");
   prediv_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr && hit(paddr, `OSCDC_ADDR_PREDIV) && pwdata[2:0] != prediv_reg) |=> pll_lose_lock)
      else $error("lock not dropped");
   wdog_once_a: assert property (@(posedge ref_clk) disable iff (!nrst || !por_nrst)
      wdog_locked_reg |=> $stable(wdog_reg)) else $error("watchdog rewritten");
   wdog_warm_a: assert property (@(posedge ref_clk) disable iff (!por_nrst)
      !nrst |=> $stable(wdog_reg)) else $error("warm reset cleared watchdog");
   feed_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (stop_mode && !watchdog_feed_in_stop) |-> !watchdog_relax_feed) else $error("feed in stop");
   sel_block_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (watchdog_source_pick && !srcsel_reg[0]) |=> !srcsel_reg[0]) else $error("sel0 set");
   sw_osc_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      switching |-> (relax_osc_on && osc_power_on)) else $error("osc off in switch");
   sw_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(switching) |-> ##[1:256] !switching) else $error("switch stuck");
   div_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (low_power_divide == 4'h0) |-> sys_clk_en) else $error("div1 gated");
   trim_load_a: assert property (@(posedge ref_clk)
      !nrst |=> trim_value == $past(flash_trim)) else $error("trim not loaded");

   sequence trim_write_s;
      wr && hit(paddr, `OSCDC_ADDR_TRIM);
   endsequence
   sequence prediv_write_s;
      wr && hit(paddr, `OSCDC_ADDR_PREDIV);
   endsequence
   sequence srcsel_write_s;
      wr && hit(paddr, `OSCDC_ADDR_SRCSEL);
   endsequence
   sequence relax_write_s;
      wr && hit(paddr, `OSCDC_ADDR_RELAX);
   endsequence
   sequence ext_write_s;
      wr && hit(paddr, `OSCDC_ADDR_EXTOSC);
   endsequence
   sequence rtc_write_s;
      wr && hit(paddr, `OSCDC_ADDR_RTC);
   endsequence
   sequence hold_done_s;
      switching && settle_cnt_reg == 8'h00;
   endsequence

   // register writes and holds
   trim_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      trim_write_s |=> trim_value == $past(pwdata[9:0]))
      else $error("trim not written");
   trim_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !(wr && hit(paddr, `OSCDC_ADDR_TRIM)) |=> $stable(trim_value))
      else $error("trim changed");
   lpd_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !(wr && hit(paddr, `OSCDC_ADDR_LPDIV)) |=> $stable(low_power_divide))
      else $error("lpd changed");
   div_two_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (sys_clk_en && low_power_divide == 4'h1 && !(wr && hit(paddr, `OSCDC_ADDR_LPDIV))) |=> !sys_clk_en)
      else $error("div2 pattern broken");
   prediv_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      prediv_write_s |=> pre_divide == $past(pwdata[2:0]))
      else $error("prediv not written");
   lock_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !(wr && hit(paddr, `OSCDC_ADDR_PREDIV)) |=> (!pll_lose_lock || stop_mode))
      else $error("spurious lock loss");
   stop_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (stop_mode && !osc_power_on) |-> pll_lose_lock)
      else $error("lock kept in stop");

   // source changeover
   srcsel_hi_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      srcsel_write_s |=> srcsel_reg[1] == $past(pwdata[1]))
      else $error("sel1 not written");
   sw_enter_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!switching && srcsel_reg != pll_src_sel) |=> switching)
      else $error("switch not started");
   sw_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (switching && settle_cnt_reg != 8'h00) |=> switching)
      else $error("hold cut short");
   src_adopt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      hold_done_s |=> (!switching && pll_src_sel == $past(srcsel_reg)))
      else $error("source not adopted");
   src_stable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !switching |=> $stable(pll_src_sel))
      else $error("source moved outside hold");

   // oscillator and watchdog controls
   relax_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      relax_write_s |=> {relax_reg[1], relax_osc_standby} == $past(pwdata[7:6]))
      else $error("relax not written");
   ext_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ext_write_s |=> ext_reg == $past(pwdata[7:4]))
      else $error("ext not written");
   rtc_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      rtc_write_s |=> {rtc_osc_on, rtc_freq_band, rtc_crystal, rtc_low_power, rtc_source_pick} == $past(pwdata[4:0]))
      else $error("rtc not written");
   wdog_first_a: assert property (@(posedge ref_clk) disable iff (!nrst || !por_nrst)
      (wr && hit(paddr, `OSCDC_ADDR_WDOG) && !wdog_locked_reg) |=> watchdog_source_pick == $past(pwdata[3]))
      else $error("first watchdog write lost");
   feed_run_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!stop_mode && relax_reg[1]) |-> watchdog_relax_feed)
      else $error("feed off while running");
   feed_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (stop_mode && watchdog_feed_in_stop && relax_reg[1]) |-> watchdog_relax_feed)
      else $error("feed dropped in stop");

   // reserved bits and idle bus
   idle_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !rd |-> prdata == 32'h0000_0000)
      else $error("read data while idle");
   lpd_rsvd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rd && hit(paddr, `OSCDC_ADDR_LPDIV)) |-> prdata[31:4] == 28'h000_0000)
      else $error("lpd reserved set");
   relax_rsvd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rd && hit(paddr, `OSCDC_ADDR_RELAX)) |-> (prdata[31:8] == 24'h00_0000 && prdata[5:0] == 6'h00))
      else $error("relax reserved set");
   wdog_rsvd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rd && hit(paddr, `OSCDC_ADDR_WDOG)) |-> (prdata[31:4] == 28'h000_0000 && !prdata[2] && !prdata[0]))
      else $error("watchdog reserved set");
endmodule : oscdc_top
`default_nettype wire

/* File: sim/oscdc_far_model.sv */
// far side model: flash trim row, reset straps and stop request
`timescale 1ns/1ps
`default_nettype none
module oscdc_far_model #(
   parameter logic [9:0] TRIM_ROW = 10'h2a5,
   parameter logic [1:0] SRC_STRAP = 2'h2
) (
   input  wire logic       stop_req,
   input  wire logic       watchdog_relax_feed,
   output logic      [9:0] flash_trim,
   output logic      [1:0] strap_src,
   output logic            strap_relax_on,
   output logic            strap_ext_on,
   output logic            strap_crystal,
   output logic            stop_mode
);
   assign flash_trim     = TRIM_ROW;
   assign strap_src      = SRC_STRAP;
   assign strap_relax_on = 1'b1;
   assign strap_ext_on   = 1'b1;
   assign strap_crystal  = 1'b1;
   assign stop_mode      = stop_req;
endmodule : oscdc_far_model
`default_nettype wire

/* File: sim/tb_osc_source_and_divider_control.sv */
// self-checking bench for oscillator source and divider control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb_osc_source_and_divider_control;
   localparam int SETTLE = 4;
   logic        ref_clk = 0, nrst = 0, por_nrst = 0, psel = 0, penable = 0, pwrite = 0, stop_req = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, sys_clk_en, pll_lose_lock, switching, relax_osc_on, osc_power_on;
   logic        relax_osc_standby, crystal_vs_oscillator, low_power_drive, ext_range_high, rtc_osc_on;
   logic        rtc_freq_band, rtc_crystal, rtc_low_power, rtc_source_pick, watchdog_feed_in_stop;
   logic        watchdog_source_pick, watchdog_relax_feed, strap_relax_on, strap_ext_on, strap_crystal, stop_mode;
   logic [9:0]  flash_trim, trim_value;
   logic [3:0]  low_power_divide;
   logic [2:0]  pre_divide;
   logic [1:0]  pll_src_sel, strap_src;
   int          errors = 0, comparisons = 0, n;
   always #25 ref_clk = ~ref_clk;
   oscdc_far_model oscdc_far_model_inst (.stop_req(stop_req), .watchdog_relax_feed(watchdog_relax_feed),
      .flash_trim(flash_trim), .strap_src(strap_src), .strap_relax_on(strap_relax_on),
      .strap_ext_on(strap_ext_on), .strap_crystal(strap_crystal), .stop_mode(stop_mode));
   oscdc_top #(.SETTLE_CYCLES(SETTLE)) oscdc_top_inst (.ref_clk(ref_clk), .nrst(nrst), .por_nrst(por_nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_trim(flash_trim), .strap_src(strap_src),
      .strap_relax_on(strap_relax_on), .strap_ext_on(strap_ext_on), .strap_crystal(strap_crystal),
      .stop_mode(stop_mode), .trim_value(trim_value), .low_power_divide(low_power_divide),
      .sys_clk_en(sys_clk_en), .pre_divide(pre_divide), .pll_lose_lock(pll_lose_lock),
      .pll_src_sel(pll_src_sel), .switching(switching), .relax_osc_on(relax_osc_on),
      .relax_osc_standby(relax_osc_standby), .osc_power_on(osc_power_on),
      .crystal_vs_oscillator(crystal_vs_oscillator), .low_power_drive(low_power_drive),
      .ext_range_high(ext_range_high), .rtc_osc_on(rtc_osc_on), .rtc_freq_band(rtc_freq_band),
      .rtc_crystal(rtc_crystal), .rtc_low_power(rtc_low_power), .rtc_source_pick(rtc_source_pick),
      .watchdog_feed_in_stop(watchdog_feed_in_stop), .watchdog_source_pick(watchdog_source_pick),
      .watchdog_relax_feed(watchdog_relax_feed));
   task close_out;
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task rst(input logic por);
      @(posedge ref_clk);
      nrst <= 1'b0; por_nrst <= ~por;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1; por_nrst <= 1'b1;
   endtask : rst
   task automatic count_hi(input int cyc, ref logic s, output int c);
      c = 0;
      repeat (cyc) begin @(negedge ref_clk); if (s === 1'b1) c++; end
   endtask : count_hi
   task t_reset_and_trim;
      apb(0, 12'h000, 0); `CHK("trim", 32'h0000_02a5, rd)
      apb(0, 12'h00c, 0); `CHK("srcsel", 32'h0000_0002, rd)
      apb(0, 12'h010, 0); `CHK("relax", 32'h0000_0080, rd)
      apb(0, 12'h014, 0); `CHK("extosc", 32'h0000_00c0, rd)
      apb(1, 12'h000, 32'hffff_ffff); apb(0, 12'h000, 0); `CHK("trim rd", 32'h0000_03ff, rd)
      `CHK("trim_value", 10'h3ff, trim_value)
      apb(0, 12'h100, 0); `CHK("unmapped", 1'b1, er)
   endtask : t_reset_and_trim
   task t_lpdiv;
      int c;
      apb(1, 12'h004, 32'h0000_00f2); @(negedge ref_clk);
      `CHK("lpd", 4'h2, low_power_divide)
      count_hi(16, sys_clk_en, c); `CHK("div4 en", 4, c)
      apb(1, 12'h004, 32'h0000_0000); count_hi(8, sys_clk_en, c); `CHK("div1 en", 8, c)
   endtask : t_lpdiv
   task t_prediv;
      int c;
      apb(1, 12'h008, 32'h0000_00fd);
      count_hi(4, pll_lose_lock, c); `CHK("lose lock", 1, c)
      `CHK("prediv", 3'h5, pre_divide)
      apb(1, 12'h008, 32'h0000_0005); count_hi(4, pll_lose_lock, c); `CHK("same value", 0, c)
      apb(0, 12'h008, 0); `CHK("prediv rd", 32'h0000_0005, rd)
   endtask : t_prediv
   task t_source;
      logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      int c, bad;
      foreach (codes[i]) begin
         apb(1, 12'h010, {24'h00_0000, codes[i] == 2'h1, 7'h00});
         apb(1, 12'h014, {24'h00_0000, codes[i] != 2'h1, 7'h00});
         apb(1, 12'h00c, {30'h0, codes[i]});
         c = 0; bad = 0;
         repeat (SETTLE + 6) begin
            @(negedge ref_clk);
            if (switching === 1'b1) begin c++; if ({relax_osc_on, osc_power_on} !== 2'b11) bad++; end
         end
         `CHK("hold len", SETTLE, c)
         `CHK("osc kept on", 0, bad)
         `CHK("pll_src_sel", codes[i], pll_src_sel)
      end
   endtask : t_source
   task t_osc_regs;
      apb(1, 12'h010, 32'hffff_ff40); @(negedge ref_clk);
      `CHK("relax", 2'b01, {relax_osc_on, relax_osc_standby})
      apb(1, 12'h014, 32'h0000_00b0); @(negedge ref_clk);
      `CHK("ext", 4'hb, {osc_power_on, crystal_vs_oscillator, low_power_drive, ext_range_high})
      apb(1, 12'h018, 32'h0000_0015); @(negedge ref_clk);
      `CHK("rtc", 5'h15, {rtc_osc_on, rtc_freq_band, rtc_crystal, rtc_low_power, rtc_source_pick})
      apb(1, 12'h018, 32'hffff_ffea); @(negedge ref_clk);
      `CHK("rtc sel", 1'b0, rtc_source_pick)
      apb(0, 12'h018, 0); `CHK("rtc rd", 32'h0000_000a, rd)
   endtask : t_osc_regs
   task t_wdog;
      apb(1, 12'h010, 32'h0000_0080);
      rst(1); apb(0, 12'h01c, 0); `CHK("wd por", 32'h0000_0000, rd)
      apb(1, 12'h01c, 32'h0000_00ff); @(negedge ref_clk);
      `CHK("wd pick", 2'b11, {watchdog_source_pick, watchdog_feed_in_stop})
      stop_req <= 1'b1; @(negedge ref_clk); `CHK("feed kept", 1'b1, watchdog_relax_feed)
      stop_req <= 1'b0;
      apb(1, 12'h01c, 32'h0000_0000); apb(0, 12'h01c, 0); `CHK("wd once", 32'h0000_000a, rd)
      rst(0); apb(0, 12'h01c, 0); `CHK("wd warm", 32'h0000_000a, rd)
      rst(1); apb(1, 12'h01c, 32'h0000_0008);
      stop_req <= 1'b1; @(negedge ref_clk); `CHK("feed gated", 1'b0, watchdog_relax_feed)
      stop_req <= 1'b0; @(negedge ref_clk); `CHK("feed back", 1'b1, watchdog_relax_feed)
      apb(1, 12'h00c, 32'h0000_0000); repeat (SETTLE + 4) @(posedge ref_clk);
      apb(1, 12'h00c, 32'h0000_0001); apb(0, 12'h00c, 0); `CHK("sel0 blocked", 32'h0000_0000, rd)
   endtask : t_wdog
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1; por_nrst <= 1'b1;
      t_reset_and_trim();
      t_lpdiv();
      t_prediv();
      t_source();
      t_osc_regs();
      t_wdog();
      close_out();
   end
   initial begin
      #1000000;
      errors++;
      close_out();
   end
endmodule : tb_osc_source_and_divider_control
`default_nettype wire
